// ==== src/aop_pkg.sv ====
package aop_pkg;

  // Register byte offsets
  localparam logic [7:0] AOP_OFF_CTRL    = 8'h00;
  localparam logic [7:0] AOP_OFF_STATUS  = 8'h04;
  localparam logic [7:0] AOP_OFF_POS_X   = 8'h08;
  localparam logic [7:0] AOP_OFF_POS_Y   = 8'h0c;
  localparam logic [7:0] AOP_OFF_IRQ_ST  = 8'h10;
  localparam logic [7:0] AOP_OFF_IRQ_EN  = 8'h14;
  localparam logic [7:0] AOP_OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] AOP_OFF_DS_POS  = 8'h1c;
  localparam logic [7:0] AOP_OFF_DS_SPD  = 8'h20;
  localparam logic [7:0] AOP_OFF_DS_DWL  = 8'h24;
  localparam logic [7:0] AOP_OFF_DS_AUX  = 8'h28;

  // Field positions: CTRL
  localparam int AOP_CTRL_REQ_BIT  = 0;
  localparam int AOP_CTRL_AXIS_LSB = 16;
  // Field positions: STATUS
  localparam int AOP_ST_XORG  = 0;
  localparam int AOP_ST_YORG  = 1;
  localparam int AOP_ST_IERR  = 2;
  // Interrupt event bits
  localparam int AOP_EV_DONE  = 0;
  localparam int AOP_EV_IERR  = 1;
  localparam int AOP_EV_SKIP  = 2;
  localparam int AOP_NEV      = 3;

  localparam logic [31:0] AOP_ZERO_POS  = 32'h0000_0000;
  localparam logic [15:0] AOP_AXIS_X    = 16'h0000;
  localparam logic [15:0] AOP_AXIS_Y    = 16'h0001;
  localparam logic [31:0] AOP_SPD_MIN   = 32'h0000_0001;
  localparam logic [31:0] AOP_SPD_MAX   = 32'h0001_86a0;
  localparam logic [15:0] AOP_DWELL_MAX = 16'hc350;
  localparam logic [1:0]  AOP_RESP_OK   = 2'b00;
  localparam logic [1:0]  AOP_RESP_ERR  = 2'b10;

  typedef struct packed {
    logic        in_motion;
    logic        axis_error;
  } aop_axis_st_t;

  // Direct-start operand set
  typedef struct packed {
    logic [31:0] target_position_operand;
    logic [31:0] target_speed_operand;
    logic [15:0] dwell_operand;
    logic [15:0] aux_code_operand;
  } aop_dstart_t;

  typedef enum logic [2:0] {
    AOP_IDLE = 3'b001,
    AOP_EXEC = 3'b010,
    AOP_ERR  = 3'b100
  } aop_state_t;

endpackage

// ==== src/aop_float_origin.sv ====
`timescale 1ns/1ps
module aop_float_origin (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset_n,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Axis state from the motion engine
  input  wire aop_pkg::aop_axis_st_t axis_x_st,
  input  wire aop_pkg::aop_axis_st_t axis_y_st,
  input  wire logic [31:0]         pos_x_in,
  input  wire logic [31:0]         pos_y_in,
  // Position preset to the motion engine
  output logic                     preset_x,
  output logic                     preset_y,
  output logic [31:0]              preset_value,
  // Direct-start operands as held
  output aop_pkg::aop_dstart_t     dstart_ops,
  output logic                     dstart_ops_ok,
  // Status and interrupt
  output logic                     x_origin_established_bit,
  output logic                     y_origin_established_bit,
  output logic                     instruction_error_flag,
  output logic                     irq
);
  import aop_pkg::*;

  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic        aw_have_reg, aw_have_next;
  logic [31:0] w_data_reg,  w_data_next;
  logic [3:0]  w_strb_reg,  w_strb_next;
  logic        w_have_reg,  w_have_next;
  logic        bvalid_reg,  bvalid_next;
  logic [1:0]  bresp_reg,   bresp_next;
  logic        rvalid_reg,  rvalid_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [1:0]  rresp_reg,   rresp_next;
  logic        req_reg,     req_next;
  logic        req_d_reg,   req_d_next;
  logic [15:0] axis_reg,    axis_next;
  logic        xorg_reg,    xorg_next;
  logic        yorg_reg,    yorg_next;
  logic        ierr_reg,    ierr_next;
  logic [AOP_NEV-1:0] ist_reg, ist_next;
  logic [AOP_NEV-1:0] ien_reg, ien_next;
  aop_dstart_t ds_reg,      ds_next;
  aop_state_t  state_reg,   state_next;
  logic        px_reg,      px_next;
  logic        py_reg,      py_next;

  logic        wr_fire;
  logic        rise;
  logic        busy_sel;
  logic [AOP_NEV-1:0] ev;
  logic [AOP_NEV-1:0] clr;
  logic [31:0] wmask;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign wr_fire       = aw_have_reg && w_have_reg && !bvalid_reg;

  // Byte-lane mask for writes
  for (genvar i = 0; i < 4; i++) begin : g_mask
    assign wmask[i*8 +: 8] = {8{w_strb_reg[i]}};
  end

  // Rising edge of the request level
  assign rise = req_reg && !req_d_reg;
  assign busy_sel = (axis_reg == AOP_AXIS_X) ?
    (axis_x_st.in_motion || axis_x_st.axis_error) :
    (axis_y_st.in_motion || axis_y_st.axis_error);

  always_comb begin
    aw_addr_next = aw_addr_reg;
    aw_have_next = aw_have_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    w_have_next  = w_have_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    req_next     = req_reg;
    axis_next    = axis_reg;
    ien_next     = ien_reg;
    ds_next      = ds_reg;
    clr          = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_next = s_axi_awaddr;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
      w_have_next = 1'b1;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = AOP_RESP_OK;
      case (aw_addr_reg)
        AOP_OFF_CTRL: begin
          if (w_strb_reg[0]) begin
            req_next = w_data_reg[AOP_CTRL_REQ_BIT];
          end
          axis_next = (axis_reg & ~wmask[31:16]) |
                      (w_data_reg[31:16] & wmask[31:16]);
        end
        AOP_OFF_IRQ_EN:  ien_next = w_data_reg[AOP_NEV-1:0];
        AOP_OFF_IRQ_CLR: clr = w_data_reg[AOP_NEV-1:0];
        AOP_OFF_DS_POS: ds_next.target_position_operand =
          (ds_reg.target_position_operand & ~wmask) | (w_data_reg & wmask);
        AOP_OFF_DS_SPD: ds_next.target_speed_operand =
          (ds_reg.target_speed_operand & ~wmask) | (w_data_reg & wmask);
        AOP_OFF_DS_DWL: ds_next.dwell_operand = w_data_reg[15:0];
        AOP_OFF_DS_AUX: ds_next.aux_code_operand = w_data_reg[15:0];
        AOP_OFF_STATUS, AOP_OFF_POS_X, AOP_OFF_POS_Y, AOP_OFF_IRQ_ST: ;
        default: bresp_next = AOP_RESP_ERR;
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = AOP_RESP_OK;
      case (s_axi_araddr)
        AOP_OFF_CTRL:   rdata_next = {axis_reg, 15'h0000, req_reg};
        AOP_OFF_STATUS: rdata_next = {29'h0000_0000, ierr_reg,
                                      yorg_reg, xorg_reg};
        AOP_OFF_POS_X:  rdata_next = pos_x_in;
        AOP_OFF_POS_Y:  rdata_next = pos_y_in;
        AOP_OFF_IRQ_ST: rdata_next = {29'h0000_0000, ist_reg};
        AOP_OFF_IRQ_EN: rdata_next = {29'h0000_0000, ien_reg};
        AOP_OFF_DS_POS: rdata_next = ds_reg.target_position_operand;
        AOP_OFF_DS_SPD: rdata_next = ds_reg.target_speed_operand;
        AOP_OFF_DS_DWL: rdata_next = {16'h0000, ds_reg.dwell_operand};
        AOP_OFF_DS_AUX: rdata_next = {16'h0000, ds_reg.aux_code_operand};
        AOP_OFF_IRQ_CLR: rdata_next = 32'h0000_0000;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = AOP_RESP_ERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Command sequencer; execution never starts motion, only a preset
  always_comb begin
    state_next = AOP_IDLE;
    xorg_next  = xorg_reg;
    yorg_next  = yorg_reg;
    ierr_next  = ierr_reg;
    px_next    = 1'b0;
    py_next    = 1'b0;
    ev         = '0;
    req_d_next = req_reg;
    case (state_reg)
      AOP_IDLE: begin
        if (rise) begin
          ierr_next = 1'b0;
          if (axis_reg != AOP_AXIS_X && axis_reg != AOP_AXIS_Y) begin
            state_next = AOP_ERR;
          end else if (busy_sel) begin
            ev[AOP_EV_SKIP] = 1'b1;
          end else begin
            state_next = AOP_EXEC;
          end
        end
      end
      AOP_EXEC: begin
        // Preset and origin flag land in the same cycle
        px_next = (axis_reg == AOP_AXIS_X);
        py_next = (axis_reg == AOP_AXIS_Y);
        if (axis_reg == AOP_AXIS_X) begin
          xorg_next = 1'b1;
        end else begin
          yorg_next = 1'b1;
        end
        ev[AOP_EV_DONE] = 1'b1;
      end
      AOP_ERR: begin
        // Per-axis error bits are inputs here and are never touched
        ierr_next = 1'b1;
        ev[AOP_EV_IERR] = 1'b1;
      end
      default: state_next = AOP_IDLE;
    endcase
    // Set wins over a clear in the same cycle
    ist_next = (ist_reg & ~clr) | ev;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      aw_addr_reg <= 8'h00;
      aw_have_reg <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      w_have_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= AOP_RESP_OK;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= AOP_RESP_OK;
      req_reg     <= 1'b0;
      req_d_reg   <= 1'b0;
      axis_reg    <= AOP_AXIS_X;
      xorg_reg    <= 1'b0;
      yorg_reg    <= 1'b0;
      ierr_reg    <= 1'b0;
      ist_reg     <= '0;
      ien_reg     <= '0;
      ds_reg      <= '0;
      state_reg   <= AOP_IDLE;
      px_reg      <= 1'b0;
      py_reg      <= 1'b0;
    end else begin
      aw_addr_reg <= aw_addr_next;
      aw_have_reg <= aw_have_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      w_have_reg  <= w_have_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      req_reg     <= req_next;
      req_d_reg   <= req_d_next;
      axis_reg    <= axis_next;
      xorg_reg    <= xorg_next;
      yorg_reg    <= yorg_next;
      ierr_reg    <= ierr_next;
      ist_reg     <= ist_next;
      ien_reg     <= ien_next;
      ds_reg      <= ds_next;
      state_reg   <= state_next;
      px_reg      <= px_next;
      py_reg      <= py_next;
    end
  end

  assign preset_x                 = px_reg;
  assign preset_y                 = py_reg;
  assign preset_value             = AOP_ZERO_POS;
  assign dstart_ops               = ds_reg;
  // Range check only; the far end may still refuse out-of-range data
  assign dstart_ops_ok = ds_reg.target_speed_operand >= AOP_SPD_MIN &&
    ds_reg.target_speed_operand <= AOP_SPD_MAX &&
    ds_reg.dwell_operand <= AOP_DWELL_MAX;
  assign x_origin_established_bit = xorg_reg;
  assign y_origin_established_bit = yorg_reg;
  assign instruction_error_flag   = ierr_reg;
  assign irq                      = |(ist_reg & ien_reg);

  a_edge_only: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg != AOP_IDLE) |-> $past(rise))
    else $error("command ran without a request edge");
  a_preset_org: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg == AOP_EXEC && axis_reg == AOP_AXIS_X) |=>
      (preset_x && xorg_reg && !preset_y))
    else $error("axis x preset or origin bit missing");
  a_bad_axis: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rise && state_reg == AOP_IDLE && axis_reg > AOP_AXIS_Y) |=>
      ##1 (ierr_reg && !preset_x && !preset_y))
    else $error("bad axis did not flag error");
  a_busy_skip: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rise && state_reg == AOP_IDLE && busy_sel) |=>
      (state_reg == AOP_IDLE) [*2])
    else $error("busy axis was not ignored");
  a_zero_only: assert property (@(posedge core_clk) disable iff (!reset_n)
    (preset_x || preset_y) |-> (preset_value == 32'h0000_0000))
    else $error("preset value not zero");
  a_speed_ok: assert property (@(posedge core_clk) disable iff (!reset_n)
    dstart_ops_ok |-> (ds_reg.target_speed_operand != 32'h0000_0000))
    else $error("zero speed reported valid");
  a_irq_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(ist_reg[AOP_EV_DONE]) && ien_reg[AOP_EV_DONE] |-> irq)
    else $error("enabled event did not raise irq");
  a_bresp_late: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_fire |=> bvalid_reg)
    else $error("write response missing");

  c_float_x: cover property (@(posedge core_clk) disable iff (!reset_n)
    preset_x);
  c_float_y: cover property (@(posedge core_clk) disable iff (!reset_n)
    preset_y);
  c_bad_axis: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(ierr_reg));
  c_skip: cover property (@(posedge core_clk) disable iff (!reset_n)
    ev[AOP_EV_SKIP]);

endmodule

// ==== sim/aop_motion_model.sv ====
`timescale 1ns/1ps
// Motion engine stand-in: moves an axis while its run bit is set and
// loads the preset value on a preset pulse.
module aop_motion_model (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // Preset from the block
  input  wire logic             preset_x,
  input  wire logic             preset_y,
  input  wire logic [31:0]      preset_value,
  // Axis conditions commanded by the bench
  input  wire logic [1:0]       run,
  input  wire logic [1:0]       fault,
  // Axis state and positions to the block
  output aop_pkg::aop_axis_st_t axis_x_st,
  output aop_pkg::aop_axis_st_t axis_y_st,
  output logic [31:0]           pos_x,
  output logic [31:0]           pos_y
);
  import aop_pkg::*;
  assign axis_x_st = {run[0], fault[0]};
  assign axis_y_st = {run[1], fault[1]};
  // Nonzero start so that a preset to zero is visible
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pos_x <= 32'h0000_0100;
      pos_y <= 32'hffff_ff00;
    end else begin
      pos_x <= preset_x ? preset_value : pos_x + {31'h0, run[0]};
      pos_y <= preset_y ? preset_value : pos_y + {31'h0, run[1]};
    end
  end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import aop_pkg::*;
  logic         core_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic [7:0]   awaddr = 8'h00;
  logic [7:0]   araddr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic         awvalid = 1'b0;
  logic         wvalid = 1'b0;
  logic         bready = 1'b0;
  logic         arvalid = 1'b0;
  logic         rready = 1'b0;
  logic [1:0]   run = 2'b00;
  logic [1:0]   fault = 2'b00;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp, rd_resp;
  logic [31:0]  rdata, pos_x, pos_y, preset_value, rd_data, pv;
  logic         preset_x, preset_y, ds_ok, xorg, yorg, ierr, irq;
  aop_axis_st_t ax_st, ay_st;
  aop_dstart_t  ds;
  logic [15:0]  av;
  logic         ds_exp;
  logic [15:0]  bad[3];
  logic [2:0]   m_st = 3'h0;
  logic [2:0]   m_en = 3'h0;
  logic [1:0]   m_org = 2'b00;
  logic         m_ierr = 1'b0;
  int           m_pre[2] = '{0, 0};
  int           sp[5] = '{0, 1, 100000, 100001, 5};
  int           dw[5] = '{0, 50000, 50000, 0, 50001};
  int           error_cnt = 0;
  int           n_compared = 0;
  int           px_cnt = 0;
  int           py_cnt = 0;

  always #5 core_clk = ~core_clk;

  aop_float_origin i_aop_float_origin (
    .core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .axis_x_st(ax_st), .axis_y_st(ay_st),
    .pos_x_in(pos_x), .pos_y_in(pos_y), .preset_x(preset_x),
    .preset_y(preset_y), .preset_value(preset_value), .dstart_ops(ds),
    .dstart_ops_ok(ds_ok), .x_origin_established_bit(xorg),
    .y_origin_established_bit(yorg), .instruction_error_flag(ierr),
    .irq(irq));

  aop_motion_model i_aop_motion_model (
    .core_clk(core_clk), .reset_n(reset_n), .preset_x(preset_x),
    .preset_y(preset_y), .preset_value(preset_value), .run(run),
    .fault(fault), .axis_x_st(ax_st), .axis_y_st(ay_st),
    .pos_x(pos_x), .pos_y(pos_y));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One transfer; the answer is waited for, never assumed
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    logic done;
    done = 1'b0;
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bready && bvalid) begin
        done = 1'b1;
        rd_resp = bresp;
        bready <= 1'b0;
      end
      if (rready && rvalid) begin
        done = 1'b1;
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
      end
    end
    if (!done) begin
      error_cnt++;
      $display("mismatch bus_answer expected response seen none");
      print_verdict();
    end
    @(posedge core_clk);
  endtask

  // Slot operand is always zero, so only the axis travels
  task automatic float_cmd(input logic [15:0] ax);
    logic busy;
    bus(1'b1, AOP_OFF_CTRL, {ax, 16'h0000});
    bus(1'b1, AOP_OFF_CTRL, {ax, 16'h0001});
    // Read only now, once the caller's own axis updates have landed
    busy = (ax == AOP_AXIS_X) ? (run[0] | fault[0]) : (run[1] | fault[1]);
    repeat (6) @(posedge core_clk);
    m_ierr = (ax > AOP_AXIS_Y);
    if (m_ierr) begin
      m_st[AOP_EV_IERR] = 1'b1;
    end else if (busy) begin
      m_st[AOP_EV_SKIP] = 1'b1;
    end else begin
      m_org[ax[0]] = 1'b1;
      m_pre[ax[0]]++;
      m_st[AOP_EV_DONE] = 1'b1;
    end
    chk("ierr", ierr, m_ierr);
    chk("x_org", xorg, m_org[0]);
    chk("y_org", yorg, m_org[1]);
    chk("px_cnt", px_cnt, m_pre[0]);
    chk("py_cnt", py_cnt, m_pre[1]);
    chk("irq", irq, |(m_st & m_en));
    bus(1'b0, AOP_OFF_STATUS, 32'h0);
    chk("status", rd_data, {29'h0, m_ierr, m_org});
    bus(1'b0, AOP_OFF_IRQ_ST, 32'h0);
    chk("irq_st", rd_data, m_st);
    bus(1'b1, AOP_OFF_IRQ_CLR, 32'h7);
    m_st = 3'h0;
    chk("irq_clr", irq, 1'b0);
  endtask

  always @(posedge core_clk) begin
    if (preset_x) px_cnt++;
    if (preset_y) py_cnt++;
    if (preset_x || preset_y)
      chk("preset_value", preset_value, AOP_ZERO_POS);
  end

  initial begin
    void'($urandom(32'h8c8c3597));
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(1'b0, AOP_OFF_STATUS, 32'h0);
    chk("status_rst", rd_data, 32'h0);
    chk("irq_rst", irq, 1'b0);
    $display("test reset done");
    bus(1'b1, AOP_OFF_IRQ_EN, 32'h7);
    chk("wr_resp", rd_resp, AOP_RESP_OK);
    m_en = 3'h7;
    float_cmd(AOP_AXIS_X);
    bus(1'b0, AOP_OFF_POS_X, 32'h0);
    chk("pos_x", rd_data, AOP_ZERO_POS);
    // Request held high must not fire again
    bus(1'b1, AOP_OFF_CTRL, 32'h1);
    repeat (6) @(posedge core_clk);
    chk("px_hold", px_cnt, m_pre[0]);
    float_cmd(AOP_AXIS_Y);
    bus(1'b0, AOP_OFF_POS_Y, 32'h0);
    chk("pos_y", rd_data, AOP_ZERO_POS);
    $display("test float_origin done");
    bad[0] = 16'h0002;
    bad[1] = 16'hffff;
    bad[2] = 16'($urandom_range(16'hffff, 2));
    foreach (bad[i]) float_cmd(bad[i]);
    $display("test bad_axis done");
    // Skip event masked: irq must stay low
    bus(1'b1, AOP_OFF_IRQ_EN, 32'h3);
    m_en = 3'h3;
    run <= 2'b01;
    float_cmd(AOP_AXIS_X);
    run <= 2'b00;
    fault <= 2'b10;
    float_cmd(AOP_AXIS_Y);
    // Program clears the axis fault before setting again
    fault <= 2'b00;
    float_cmd(AOP_AXIS_Y);
    $display("test busy_axis done");
    for (int i = 0; i < 5; i++) begin
      pv = $urandom();
      av = 16'($urandom());
      bus(1'b1, AOP_OFF_DS_POS, pv);
      bus(1'b1, AOP_OFF_DS_SPD, 32'(sp[i]));
      bus(1'b1, AOP_OFF_DS_DWL, 32'(dw[i]));
      bus(1'b1, AOP_OFF_DS_AUX, {16'h0, av});
      ds_exp = sp[i] >= 1 && sp[i] <= 100000 && dw[i] <= 50000;
      chk("ds_pos", ds.target_position_operand, pv);
      chk("ds_spd", ds.target_speed_operand, 32'(sp[i]));
      chk("ds_dwl", ds.dwell_operand, 32'(dw[i]));
      chk("ds_aux", ds.aux_code_operand, av);
      chk("ds_ok", ds_ok, ds_exp);
    end
    $display("test direct_start done");
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped_resp", rd_resp, AOP_RESP_ERR);
    chk("unmapped_data", rd_data, 32'h0);
    bus(1'b1, 8'h40, 32'h0);
    chk("unmapped_wr", rd_resp, AOP_RESP_ERR);
    $display("test unmapped done");
    print_verdict();
  end
endmodule
